// [hdl/rsq_pkg.sv]
// shared constants for the reset state and interrupt source block
package rsq_pkg;
  localparam int unsigned CLK_MHZ = 250;

  // apb byte offsets
  localparam logic [7:0] OFF_TIMER_A_MODE   = 8'h00;
  localparam logic [7:0] OFF_TIMER_B_MODE1  = 8'h04;
  localparam logic [7:0] OFF_TIMER_B_MODE2  = 8'h08;
  localparam logic [7:0] OFF_TIMER_C_MODE1  = 8'h0c;
  localparam logic [7:0] OFF_TIMER_C_MODE2  = 8'h10;
  localparam logic [7:0] OFF_SYS_PRESCALER  = 8'h14;
  localparam logic [7:0] OFF_WATCH_PRESC    = 8'h18;
  localparam logic [7:0] OFF_TIMER_A_COUNT  = 8'h1c;
  localparam logic [7:0] OFF_TIMER_B_COUNT  = 8'h20;
  localparam logic [7:0] OFF_TIMER_C_COUNT  = 8'h24;
  localparam logic [7:0] OFF_TIMER_B_RELOAD = 8'h28;
  localparam logic [7:0] OFF_TIMER_C_RELOAD = 8'h2c;
  localparam logic [7:0] OFF_SERIAL_MODE1   = 8'h30;
  localparam logic [7:0] OFF_SERIAL_MODE2   = 8'h34;
  localparam logic [7:0] OFF_SERIAL_SHIFT   = 8'h38;
  localparam logic [7:0] OFF_SERIAL_BITCNT  = 8'h3c;
  localparam logic [7:0] OFF_CONV_MODE      = 8'h40;
  localparam logic [7:0] OFF_CONV_RESULT    = 8'h44;
  localparam logic [7:0] OFF_BIT_FLAGS      = 8'h48;
  localparam logic [7:0] OFF_MISC_CONTROL   = 8'h4c;
  localparam logic [7:0] OFF_CLOCK_SOURCE   = 8'h50;
  localparam logic [7:0] OFF_POWERDOWN1     = 8'h54;
  localparam logic [7:0] OFF_POWERDOWN2     = 8'h58;
  localparam logic [7:0] OFF_IRQ_FLAGS      = 8'h5c;
  localparam logic [7:0] OFF_IRQ_MASK       = 8'h60;
  localparam logic [7:0] OFF_IRQ_ENABLE     = 8'h64;
  localparam logic [7:0] OFF_IRQ_VECTOR     = 8'h68;
  localparam logic [7:0] OFF_CORE_REGS      = 8'h70;
  localparam logic [7:0] OFF_RAM_BASE       = 8'h80;
  localparam int unsigned RAM_WORDS         = 16;

  // reset values
  localparam logic [3:0]  RST_MODE4      = 4'h0;
  localparam logic [2:0]  RST_TB_MODE2   = 3'h0;
  localparam logic [0:0]  RST_TC_MODE2   = 1'h0;
  localparam logic [11:0] RST_SYS_PRESC  = 12'h000;
  localparam logic [7:0]  RST_COUNT8     = 8'h00;
  localparam logic [3:0]  RST_RELOAD_LO  = 4'h0;
  localparam logic [2:0]  RST_BITCNT     = 3'h0;
  localparam logic [3:0]  RST_RESULT_UP  = 4'h7;
  localparam logic [3:0]  RST_RESULT_MID = 4'hf;
  localparam logic [1:0]  RST_RESULT_LOW = 2'h3;
  localparam logic [4:0]  RST_BIT_FLAGS  = 5'h00;
  localparam logic [2:0]  RST_MISC       = 3'h0;
  localparam logic [1:0]  RST_PD2        = 2'h0;
  localparam logic [6:0]  RST_IRQ_MASK   = 7'h7f;

  // field positions
  localparam int unsigned BF_LOW_SPEED = 0;
  localparam int unsigned BF_WATCHDOG  = 1;
  localparam int unsigned BF_CONV_GO   = 2;
  localparam int unsigned BF_DIRECT    = 3;
  localparam int unsigned BF_GEAR      = 4;
  localparam int unsigned SM2_CLR_BIT  = 2;
  localparam int unsigned SM2_UND_BIT  = 1;
  localparam int unsigned PD1_TIMER_A  = 0;
  localparam int unsigned PD1_TIMER_BC = 1;

  // interrupt sources, index is priority order
  localparam int unsigned SRC_WAKE   = 0;
  localparam int unsigned SRC_EXT    = 1;
  localparam int unsigned SRC_TA     = 2;
  localparam int unsigned SRC_TB     = 3;
  localparam int unsigned SRC_TC     = 4;
  localparam int unsigned SRC_SERIAL = 5;
  localparam int unsigned SRC_CONV   = 6;
  localparam int unsigned NUM_SRC    = 7;

  localparam logic [13:0] VEC_WAKE   = 14'h0002;
  localparam logic [13:0] VEC_EXT    = 14'h0004;
  localparam logic [13:0] VEC_TA     = 14'h0008;
  localparam logic [13:0] VEC_TB     = 14'h000a;
  localparam logic [13:0] VEC_TC     = 14'h000c;
  localparam logic [13:0] VEC_SHARED = 14'h000e;
  localparam logic [13:0] VEC_NONE   = 14'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_FINISH, ST_SAVE, ST_JUMP} rsq_seq_t;
endpackage

// [hdl/rsq_retain_bank.sv]
// core working registers and ram that no reset touches
module rsq_retain_bank (
  input  wire logic        clk_in,    // system clock
  input  wire logic        wr_in,     // write strobe
  input  wire logic [4:0]  sel_in,    // 0 core regs, 16..31 ram words
  input  wire logic [31:0] wdata_in,  // write data
  output logic      [31:0] rdata_out  // read data
);
  typedef struct packed {
    logic       carry_flag;
    logic [1:0] w;
    logic [3:0] a;
    logic [3:0] b;
    logic [3:0] x;
    logic [3:0] x_auxiliary;
    logic [3:0] y;
    logic [3:0] y_auxiliary;
  } rsq_core_t;

  rsq_core_t  core_r;
  rsq_core_t  core_nxt;
  logic [3:0] ram_r [rsq_pkg::RAM_WORDS];

  always_comb begin
    core_nxt = core_r;
    if (wr_in && sel_in == 5'h00) begin
      core_nxt = rsq_core_t'(wdata_in[26:0]);
    end
  end

  // no reset branch: contents survive any reset and stop
  always_ff @(posedge clk_in) begin
    core_r <= core_nxt;
    if (wr_in && sel_in[4]) begin
      ram_r[sel_in[3:0]] <= wdata_in[3:0];
    end
  end

  always_comb begin
    if (sel_in[4]) begin
      rdata_out = {28'h0000000, ram_r[sel_in[3:0]]};
    end else if (sel_in == 5'h00) begin
      rdata_out = {5'h00, core_r};
    end else begin
      rdata_out = 32'h00000000;
    end
  end
endmodule // rsq_retain_bank

// [hdl/rsq_irq_ctrl.sv]
// interrupt flags, masks, global enable, priority and accept sequence
module rsq_irq_ctrl (
  input  wire logic        clk_in,       // system clock
  input  wire logic        rst_in,       // synchronous reset, high
  input  wire logic [6:0]  event_in,     // one-cycle source events
  input  wire logic        flag_clr_in,  // write-one-to-clear strobe
  input  wire logic        mask_wr_in,   // mask write strobe
  input  wire logic        ie_wr_in,     // global enable write strobe
  input  wire logic [6:0]  wdata_in,     // write data
  input  wire logic        rtni_in,      // return from interrupt, sets enable
  input  wire logic        instr_end_in, // instruction boundary
  output logic      [6:0]  flags_out,    // request flags
  output logic      [6:0]  mask_out,     // mask bits, 1 masks
  output logic             ie_out,       // global enable
  output logic             irq_out,      // unmasked request pending
  output logic             save_out,     // stack save cycles
  output logic             jump_out,     // jump to vector cycle
  output logic      [13:0] vector_out    // vector of accepted source
);
  typedef struct packed {
    rsq_pkg::rsq_seq_t seq;
    logic [6:0]        flags;
    logic [6:0]        mask;
    logic              ie;
    logic              irq;
    logic              save;
    logic              jump;
    logic [13:0]       vector;
  } rsq_irq_st_t;

  rsq_irq_st_t st_r;
  rsq_irq_st_t st_nxt;
  logic [6:0]  req;

  function automatic logic [13:0] pick_vector(input logic [6:0] r);
    logic [13:0] v;
    v = rsq_pkg::VEC_NONE;
    if (r[rsq_pkg::SRC_WAKE]) v = rsq_pkg::VEC_WAKE;
    else if (r[rsq_pkg::SRC_EXT]) v = rsq_pkg::VEC_EXT;
    else if (r[rsq_pkg::SRC_TA]) v = rsq_pkg::VEC_TA;
    else if (r[rsq_pkg::SRC_TB]) v = rsq_pkg::VEC_TB;
    else if (r[rsq_pkg::SRC_TC]) v = rsq_pkg::VEC_TC;
    else if (r[rsq_pkg::SRC_SERIAL] || r[rsq_pkg::SRC_CONV]) v = rsq_pkg::VEC_SHARED;
    return v;
  endfunction

  assign req = st_r.flags & ~st_r.mask;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.irq  = |req;
    st_nxt.save = 1'b0;
    st_nxt.jump = 1'b0;
    if (mask_wr_in) begin
      st_nxt.mask = wdata_in;
    end
    // set wins over clear; software can only clear flags
    st_nxt.flags = (st_r.flags & ~(flag_clr_in ? wdata_in : 7'h00)) | event_in;
    if (ie_wr_in) begin
      st_nxt.ie = wdata_in[0];
    end
    if (rtni_in) begin
      st_nxt.ie = 1'b1;
    end
    unique case (st_r.seq)
      rsq_pkg::ST_IDLE: begin
        if (instr_end_in && st_r.ie && |req) begin
          st_nxt.seq    = rsq_pkg::ST_FINISH;
          st_nxt.vector = pick_vector(req);
        end
      end
      rsq_pkg::ST_FINISH: begin
        st_nxt.seq  = rsq_pkg::ST_SAVE;
        st_nxt.ie   = 1'b0;
        st_nxt.save = 1'b1;
      end
      rsq_pkg::ST_SAVE: begin
        st_nxt.seq  = rsq_pkg::ST_JUMP;
        st_nxt.save = 1'b1;
        st_nxt.jump = 1'b1;
      end
      rsq_pkg::ST_JUMP: begin
        st_nxt.seq = rsq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r        <= '0;
      st_r.mask   <= rsq_pkg::RST_IRQ_MASK;
      st_r.seq    <= rsq_pkg::ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_out  = st_r.flags;
  assign mask_out   = st_r.mask;
  assign ie_out     = st_r.ie;
  assign irq_out    = st_r.irq;
  assign save_out   = st_r.save;
  assign jump_out   = st_r.jump;
  assign vector_out = st_r.vector;
endmodule // rsq_irq_ctrl

// [hdl/rsq_reset_irq.sv]
// peripheral reset state, retained core state and interrupt sources behind apb
// Functional notes
// - reset clears timer mode registers, implemented bits
// - reload low nibble, prescalers, counters cleared
// - serial mode 1, serial mode 2 bit 2 and bit counter cleared; mode 2 bit 1 and data kept
// - converter mode cleared, result 0111 1111 11
// - five control bit flags cleared on reset
// - misc, clock source, power-down registers cleared
// - wake from stop keeps core registers, ram
// - seven interrupt sources provided
// - each source has flag, mask, vector
// - global enable gates all interrupt acceptance
// - converter and serial share one vector
// - fixed priorities and vector addresses
// - request when flag set, mask clear
// - reset: enable and flags clear, masks set
// - accept: finish, clear enable, save, jump
module rsq_reset_irq (
  input  wire logic        clk_in,          // system clock, 250 mhz
  input  wire logic        rst_in,          // synchronous reset, high
  input  wire logic        psel_in,         // apb select
  input  wire logic        penable_in,      // apb enable
  input  wire logic        pwrite_in,       // apb direction
  input  wire logic [7:0]  paddr_in,        // apb byte address
  input  wire logic [31:0] pwdata_in,       // apb write data
  output logic      [31:0] prdata_out,      // apb read data
  output logic             pready_out,      // apb ready
  output logic             pslverr_out,     // apb error, unmapped address
  input  wire logic        wake_input_n_in, // wake pin, falling edge event
  input  wire logic        ext_irq_n_in,    // external irq pin, falling edge
  input  wire logic        serial_bit_in,   // serial bit strobe
  input  wire logic        serial_data_in,  // serial data bit
  input  wire logic        conv_done_in,    // converter done strobe
  input  wire logic [9:0]  conv_result_in,  // converter result
  input  wire logic        rtni_in,         // return from interrupt
  input  wire logic        instr_end_in,    // instruction boundary
  output logic             irq_out,         // unmasked request level
  output logic             save_out,        // stack save cycles
  output logic             jump_out,        // jump cycle
  output logic      [13:0] vector_out       // vector address
);
  typedef struct packed {
    logic [3:0]  timer_a_mode;
    logic [3:0]  timer_b_mode_first;
    logic [2:0]  timer_b_mode_second;
    logic [3:0]  timer_c_mode_first;
    logic [0:0]  timer_c_mode_second;
    logic [11:0] system_prescaler;
    logic [7:0]  watch_prescaler;
    logic [7:0]  timer_a_count;
    logic [7:0]  timer_b_count;
    logic [7:0]  timer_c_count;
    logic [7:0]  timer_b_reload_write;
    logic [7:0]  timer_c_reload_write;
    logic [3:0]  serial_mode_first;
    logic [2:1]  serial_mode_second;
    logic [7:0]  serial_shift_data;
    logic [2:0]  serial_bitcnt;
    logic [3:0]  converter_mode;
    logic [9:0]  converter_result;
    logic [4:0]  bit_flags;
    logic [2:0]  misc_control;
    logic [3:0]  clock_source_select;
    logic [1:0]  module_powerdown_first;
    logic [1:0]  module_powerdown_second;
    logic        wake_d;
    logic        ext_d;
    logic [6:0]  events;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rsq_st_t;

  rsq_st_t     st_r;
  rsq_st_t     st_nxt;
  logic        wr_stb;
  logic        rd_setup;
  logic        wr_ok;
  logic [6:0]  irq_flags;
  logic [6:0]  irq_mask;
  logic        irq_ie;
  logic [31:0] bank_rdata;
  logic [4:0]  bank_sel;
  logic        bank_hit;
  logic        ps_tick;

  // write takes effect on the edge where ready is sampled high
  assign wr_stb   = psel_in && penable_in && st_r.pready && pwrite_in;
  assign rd_setup = psel_in && penable_in && !st_r.pready;
  // plain expression so the strobes follow the bus every cycle
  assign wr_ok    = wr_stb && !st_r.pslverr;

  function automatic logic wr_to(input logic [7:0] off);
    return wr_stb && !st_r.pslverr && paddr_in == off;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic m;
    m = (a[1:0] == 2'h0) && ((a <= rsq_pkg::OFF_IRQ_VECTOR) || (a == rsq_pkg::OFF_CORE_REGS) ||
        (a >= rsq_pkg::OFF_RAM_BASE && a < rsq_pkg::OFF_RAM_BASE + 8'h40));
    return m;
  endfunction

  assign bank_hit = paddr_in >= rsq_pkg::OFF_RAM_BASE;
  assign bank_sel = bank_hit ? {1'b1, paddr_in[5:2]} : 5'h00;

  rsq_retain_bank u_bank (
    .clk_in    (clk_in),
    .wr_in     (wr_stb && !st_r.pslverr && (bank_hit || paddr_in == rsq_pkg::OFF_CORE_REGS)),
    .sel_in    (bank_sel),
    .wdata_in  (pwdata_in),
    .rdata_out (bank_rdata)
  );

  rsq_irq_ctrl u_irq (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .event_in     (st_r.events),
    .flag_clr_in  (wr_ok && paddr_in == rsq_pkg::OFF_IRQ_FLAGS),
    .mask_wr_in   (wr_ok && paddr_in == rsq_pkg::OFF_IRQ_MASK),
    .ie_wr_in     (wr_ok && paddr_in == rsq_pkg::OFF_IRQ_ENABLE),
    .wdata_in     (pwdata_in[6:0]),
    .rtni_in      (rtni_in),
    .instr_end_in (instr_end_in),
    .flags_out    (irq_flags),
    .mask_out     (irq_mask),
    .ie_out       (irq_ie),
    .irq_out      (irq_out),
    .save_out     (save_out),
    .jump_out     (jump_out),
    .vector_out   (vector_out)
  );

  // read mux; bits that do not exist read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    unique case (a)
      rsq_pkg::OFF_TIMER_A_MODE:   d[3:0]  = st_r.timer_a_mode;
      rsq_pkg::OFF_TIMER_B_MODE1:  d[3:0]  = st_r.timer_b_mode_first;
      rsq_pkg::OFF_TIMER_B_MODE2:  d[2:0]  = st_r.timer_b_mode_second;
      rsq_pkg::OFF_TIMER_C_MODE1:  d[3:0]  = st_r.timer_c_mode_first;
      rsq_pkg::OFF_TIMER_C_MODE2:  d[0:0]  = st_r.timer_c_mode_second;
      rsq_pkg::OFF_SYS_PRESCALER:  d[11:0] = st_r.system_prescaler;
      rsq_pkg::OFF_WATCH_PRESC:    d[7:0]  = st_r.watch_prescaler;
      rsq_pkg::OFF_TIMER_A_COUNT:  d[7:0]  = st_r.timer_a_count;
      rsq_pkg::OFF_TIMER_B_COUNT:  d[7:0]  = st_r.timer_b_count;
      rsq_pkg::OFF_TIMER_C_COUNT:  d[7:0]  = st_r.timer_c_count;
      rsq_pkg::OFF_TIMER_B_RELOAD: d[7:0]  = st_r.timer_b_reload_write;
      rsq_pkg::OFF_TIMER_C_RELOAD: d[7:0]  = st_r.timer_c_reload_write;
      rsq_pkg::OFF_SERIAL_MODE1:   d[3:0]  = st_r.serial_mode_first;
      rsq_pkg::OFF_SERIAL_MODE2:   d[2:1]  = st_r.serial_mode_second;
      rsq_pkg::OFF_SERIAL_SHIFT:   d[7:0]  = st_r.serial_shift_data;
      rsq_pkg::OFF_SERIAL_BITCNT:  d[2:0]  = st_r.serial_bitcnt;
      rsq_pkg::OFF_CONV_MODE:      d[3:0]  = st_r.converter_mode;
      rsq_pkg::OFF_CONV_RESULT:    d[9:0]  = st_r.converter_result;
      rsq_pkg::OFF_BIT_FLAGS:      d[4:0]  = st_r.bit_flags;
      rsq_pkg::OFF_MISC_CONTROL:   d[3:0]  = {st_r.misc_control[2], 1'b0, st_r.misc_control[1:0]};
      rsq_pkg::OFF_CLOCK_SOURCE:   d[3:0]  = st_r.clock_source_select;
      rsq_pkg::OFF_POWERDOWN1:     d[1:0]  = st_r.module_powerdown_first;
      rsq_pkg::OFF_POWERDOWN2:     d[1:0]  = st_r.module_powerdown_second;
      rsq_pkg::OFF_IRQ_FLAGS:      d[6:0]  = irq_flags;
      rsq_pkg::OFF_IRQ_MASK:       d[6:0]  = irq_mask;
      rsq_pkg::OFF_IRQ_ENABLE:     d[0]    = irq_ie;
      rsq_pkg::OFF_IRQ_VECTOR:     d[13:0] = vector_out;
      default:                     d       = bank_rdata;
    endcase
    return d;
  endfunction

  always_comb begin
    st_nxt = st_r;

    // apb: ready one cycle into the access phase
    st_nxt.pready  = rd_setup;
    st_nxt.pslverr = rd_setup && !is_mapped(paddr_in);
    st_nxt.prdata  = (rd_setup && !pwrite_in && is_mapped(paddr_in)) ? read_mux(paddr_in) : 32'h00000000;

    // register writes, only implemented bits stored
    if (wr_to(rsq_pkg::OFF_TIMER_A_MODE))   st_nxt.timer_a_mode         = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_TIMER_B_MODE1))  st_nxt.timer_b_mode_first   = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_TIMER_B_MODE2))  st_nxt.timer_b_mode_second  = pwdata_in[2:0];
    if (wr_to(rsq_pkg::OFF_TIMER_C_MODE1))  st_nxt.timer_c_mode_first   = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_TIMER_C_MODE2))  st_nxt.timer_c_mode_second  = pwdata_in[0:0];
    if (wr_to(rsq_pkg::OFF_TIMER_B_RELOAD)) st_nxt.timer_b_reload_write = pwdata_in[7:0];
    if (wr_to(rsq_pkg::OFF_TIMER_C_RELOAD)) st_nxt.timer_c_reload_write = pwdata_in[7:0];
    if (wr_to(rsq_pkg::OFF_SERIAL_MODE1))   st_nxt.serial_mode_first    = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_SERIAL_MODE2))   st_nxt.serial_mode_second   = pwdata_in[2:1];
    if (wr_to(rsq_pkg::OFF_SERIAL_SHIFT))   st_nxt.serial_shift_data    = pwdata_in[7:0];
    if (wr_to(rsq_pkg::OFF_CONV_MODE))      st_nxt.converter_mode       = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_BIT_FLAGS))      st_nxt.bit_flags            = pwdata_in[4:0];
    if (wr_to(rsq_pkg::OFF_MISC_CONTROL))   st_nxt.misc_control         = {pwdata_in[3], pwdata_in[1:0]};
    if (wr_to(rsq_pkg::OFF_CLOCK_SOURCE))   st_nxt.clock_source_select  = pwdata_in[3:0];
    if (wr_to(rsq_pkg::OFF_POWERDOWN1))     st_nxt.module_powerdown_first  = pwdata_in[1:0];
    if (wr_to(rsq_pkg::OFF_POWERDOWN2))     st_nxt.module_powerdown_second = pwdata_in[1:0];

    // source events, one cycle each
    st_nxt.events = 7'h00;
    st_nxt.wake_d = wake_input_n_in;
    st_nxt.ext_d  = ext_irq_n_in;
    st_nxt.events[rsq_pkg::SRC_WAKE] = st_r.wake_d && !wake_input_n_in;
    st_nxt.events[rsq_pkg::SRC_EXT]  = st_r.ext_d && !ext_irq_n_in;

    // prescalers and timers
    st_nxt.system_prescaler = st_r.system_prescaler + 12'h001;
    st_nxt.watch_prescaler  = st_r.watch_prescaler + 8'h01;
    ps_tick = &st_r.system_prescaler;
    if (ps_tick && !st_r.module_powerdown_first[rsq_pkg::PD1_TIMER_A]) begin
      st_nxt.timer_a_count = st_r.timer_a_count + 8'h01;
      st_nxt.events[rsq_pkg::SRC_TA] = &st_r.timer_a_count;
    end
    if (ps_tick && !st_r.module_powerdown_first[rsq_pkg::PD1_TIMER_BC]) begin
      st_nxt.timer_b_count = (&st_r.timer_b_count) ? st_r.timer_b_reload_write : st_r.timer_b_count + 8'h01;
      st_nxt.timer_c_count = (&st_r.timer_c_count) ? st_r.timer_c_reload_write : st_r.timer_c_count + 8'h01;
      st_nxt.events[rsq_pkg::SRC_TB] = &st_r.timer_b_count;
      st_nxt.events[rsq_pkg::SRC_TC] = &st_r.timer_c_count;
    end

    // serial shift, eight bits end a transfer
    if (serial_bit_in) begin
      st_nxt.serial_shift_data = {st_r.serial_shift_data[6:0], serial_data_in};
      st_nxt.serial_bitcnt     = st_r.serial_bitcnt + 3'h1;
      st_nxt.events[rsq_pkg::SRC_SERIAL] = &st_r.serial_bitcnt;
    end

    // converter result; done clears the start bit
    if (conv_done_in) begin
      st_nxt.converter_result = conv_result_in;
      st_nxt.bit_flags[rsq_pkg::BF_CONV_GO] = 1'b0;
      st_nxt.events[rsq_pkg::SRC_CONV] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r.timer_a_mode            <= rsq_pkg::RST_MODE4;
      st_r.timer_b_mode_first      <= rsq_pkg::RST_MODE4;
      st_r.timer_b_mode_second     <= rsq_pkg::RST_TB_MODE2;
      st_r.timer_c_mode_first      <= rsq_pkg::RST_MODE4;
      st_r.timer_c_mode_second     <= rsq_pkg::RST_TC_MODE2;
      st_r.system_prescaler        <= rsq_pkg::RST_SYS_PRESC;
      st_r.watch_prescaler         <= rsq_pkg::RST_COUNT8;
      st_r.timer_a_count           <= rsq_pkg::RST_COUNT8;
      st_r.timer_b_count           <= rsq_pkg::RST_COUNT8;
      st_r.timer_c_count           <= rsq_pkg::RST_COUNT8;
      // upper reload nibbles keep their value
      st_r.timer_b_reload_write    <= {st_r.timer_b_reload_write[7:4], rsq_pkg::RST_RELOAD_LO};
      st_r.timer_c_reload_write    <= {st_r.timer_c_reload_write[7:4], rsq_pkg::RST_RELOAD_LO};
      st_r.serial_mode_first       <= rsq_pkg::RST_MODE4;
      st_r.serial_mode_second      <= {1'b0, st_r.serial_mode_second[rsq_pkg::SM2_UND_BIT]};
      st_r.serial_shift_data       <= st_r.serial_shift_data;
      st_r.serial_bitcnt           <= rsq_pkg::RST_BITCNT;
      st_r.converter_mode          <= rsq_pkg::RST_MODE4;
      st_r.converter_result        <= {rsq_pkg::RST_RESULT_UP, rsq_pkg::RST_RESULT_MID, rsq_pkg::RST_RESULT_LOW};
      st_r.bit_flags               <= rsq_pkg::RST_BIT_FLAGS;
      st_r.misc_control            <= rsq_pkg::RST_MISC;
      st_r.clock_source_select     <= rsq_pkg::RST_MODE4;
      st_r.module_powerdown_first  <= rsq_pkg::RST_PD2;
      st_r.module_powerdown_second <= rsq_pkg::RST_PD2;
      st_r.wake_d                  <= 1'b1;
      st_r.ext_d                   <= 1'b1;
      st_r.events                  <= 7'h00;
      st_r.pready                  <= 1'b0;
      st_r.pslverr                 <= 1'b0;
      st_r.prdata                  <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_out  = st_r.prdata;
  assign pready_out  = st_r.pready;
  assign pslverr_out = st_r.pslverr;
endmodule // rsq_reset_irq

// [sim/rsq_reset_irq_sva.sv]
// port assertions for the reset state and interrupt block
module rsq_chk (
  input wire logic        clk_in,      // clock
  input wire logic        rst_in,      // reset
  input wire logic        psel_in,     // select
  input wire logic        penable_in,  // enable
  input wire logic [7:0]  paddr_in,    // address
  input wire logic [31:0] prdata_out,  // read data
  input wire logic        pready_out,  // ready
  input wire logic        pslverr_out, // error
  input wire logic        irq_out,     // request level
  input wire logic        save_out,    // save cycles
  input wire logic        jump_out,    // jump cycle
  input wire logic [13:0] vector_out   // vector
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_rst_quiet: assert property ($fell(rst_in) |-> !irq_out && !save_out && !jump_out && vector_out == 14'h0000)
    else $error("outputs not idle after reset");
  a_save_jump: assert property ($rose(save_out) |=> save_out && jump_out)
    else $error("save not followed by jump");
  a_jump_end: assert property (jump_out |=> !save_out && !jump_out)
    else $error("accept sequence too long");
  a_vec_legal: assert property (jump_out |-> vector_out inside {14'h2, 14'h4, 14'h8, 14'ha, 14'hc, 14'he})
    else $error("jump to illegal vector");
  a_save_cause: assert property ($rose(save_out) |-> $past(irq_out))
    else $error("accept without request");
  a_err_unmapped: assert property (pready_out && paddr_in >= 8'hc0 |-> pslverr_out)
    else $error("unmapped access not refused");
  a_ready_time: assert property (psel_in && penable_in && !$past(penable_in) |=> pready_out)
    else $error("ready late");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
endmodule // rsq_chk
bind rsq_reset_irq rsq_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .irq_out(irq_out), .save_out(save_out), .jump_out(jump_out), .vector_out(vector_out));

// [sim/rsq_reset_irq_bench.sv]
// self-checking bench for the reset state and interrupt block
module rsq_reset_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic        wake_n = 1'b1, ext_n = 1'b1, ser_bit = 1'b0, conv_done = 1'b0;
  logic        pready_out, pslverr_out, irq_out, save_out, jump_out, err;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [13:0] vector_out;
  int          miscompares = 0, check_count = 0, src[4] = '{0, 1, 5, 6};
  always #2 clk_in = ~clk_in;
  rsq_reset_irq DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .wake_input_n_in(wake_n), .ext_irq_n_in(ext_n),
    .serial_bit_in(ser_bit), .serial_data_in(1'b0), .conv_done_in(conv_done), .conv_result_in(10'h2a5),
    .rtni_in(1'b0), .instr_end_in(1'b1), .irq_out(irq_out), .save_out(save_out), .jump_out(jump_out),
    .vector_out(vector_out));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic fire(input int s);
    if (s == 5) repeat (8) begin
      ser_bit <= 1'b1;
      @(posedge clk_in);
      ser_bit <= 1'b0;
      @(posedge clk_in);
    end
    wake_n <= s != 0;
    ext_n <= s != 1;
    conv_done <= s == 6;
    repeat (2) @(posedge clk_in);
    {wake_n, ext_n, conv_done} <= 3'b110;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    for (int a = 0; a < 8'h6c; a += 4) apb(1'b1, 8'(a), 32'hffffffff);
    apb(1'b1, 8'h70, 32'h05a5a5a5);
    apb(1'b1, 8'h84, 32'h0000000c);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // prescalers restart from zero and count every clock
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h6);
    for (int a = 0; a <= 8'h6c; a += 4) if (!(a inside {8'h14, 8'h18, 8'h38})) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd & (a == 8'h28 || a == 8'h2c ? 32'hf : a == 8'h34 ? 32'h4 : '1), a == 8'h44 ? 32'h1ff : a == 8'h60 ? 32'h7f : 32'h0);
      chk(err, a == 8'h6c);
    end
    apb(1'b0, 8'h70, 32'h0);
    chk(rd, 32'h05a5a5a5);
    apb(1'b0, 8'h84, 32'h0);
    chk(rd, 32'hc);
    apb(1'b0, 8'hc0, 32'h0);
    chk(err, 1'b1);
    $display("test reset values done");
    fire(1);
    chk(irq_out, 1'b0);
    apb(1'b1, 8'h5c, 32'h2);
    foreach (src[i]) begin
      apb(1'b1, 8'h60, ~(32'h1 << src[i]));
      fire(src[i]);
      chk(irq_out, 1'b1);
      chk(save_out, 1'b0);
      apb(1'b1, 8'h64, 32'h1);
      while (jump_out !== 1'b1) @(posedge clk_in);
      chk(vector_out, src[i] == 0 ? 14'h2 : src[i] == 1 ? 14'h4 : 14'he);
      apb(1'b0, 8'h5c, 32'h0);
      chk(rd, 32'h1 << src[i]);
      apb(1'b0, 8'h64, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h5c, 32'h1 << src[i]);
      apb(1'b1, 8'h60, 32'h7f);
      chk(irq_out, 1'b0);
    end
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h2a5);
    $display("test interrupt sources done");
    print_verdict;
  end
endmodule // rsq_reset_irq_bench
